// *** hw/nmm_manager.sv ***
/*
 * Node power mode manager: source selection, charge control, button decode,
 * charge gauge, power LED sequence, standby, snooze and sleep sequencing.
 * Assumes source-present and link pins are asynchronous, the charge level
 * comes from battery manager logic on clk, and the register port on clk.
 */
`timescale 1ns/1ns
`default_nettype none
module nmm_manager
    import nmm_pkg::*;
#(
    parameter int unsigned MS_DIV = MS_CYCLES
)(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  buttonPin,
    input  wire logic                  extPresentPin,
    input  wire logic                  ethPresentPin,
    input  wire logic                  hostLinkPin,
    input  wire logic [6:0]            chargePct,
    input  wire logic [3:0]            regAddr,
    input  wire logic [31:0]           regWdata,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic      [31:0]           regRdata,
    output logic                       nodePowerOn,
    output logic                       extPowerSelect,
    output logic                       ethPowerSelect,
    output logic                       chargeEnable,
    output logic                       sensorExcitationOn,
    output logic                       commEnable,
    output logic                       powerLedGreen,
    output logic                       powerLedRed,
    output logic                       gaugeRed,
    output logic [GAUGE_LEDS-1:0]      gaugeGreen
);
    import nmm_pkg::*;

    // ==========================================================
    // declarations
    nmm_state_t  state;
    nmm_state_t  next_state;
    logic [2:0]  syncA;
    logic [2:0]  syncB;
    logic [16:0] divCnt;
    logic        msTick;
    logic [9:0]  msInSec;
    logic        secTick;
    logic [15:0] stateMs;
    logic [15:0] stateSec;
    logic        everLinked;
    logic        standby;
    logic [15:0] snoozeSec;
    logic [15:0] awakeSec;
    logic [15:0] postSnoozeSec;
    logic [31:0] wakeTime;
    logic [31:0] timeOfDay;
    logic        gaugeActive;
    logic [11:0] gaugeMs;
    logic [2:0]  gaugeLevel;
    logic        shortPress;
    logic        longPress;
    logic [31:0] next_rdata;

    // ==========================================================
    // pin synchronisers
    wire [2:0] rawPins = {hostLinkPin, ethPresentPin, extPresentPin};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    syncA[gi] <= 1'b0;
                    syncB[gi] <= 1'b0;
                end else begin
                    syncA[gi] <= rawPins[gi];
                    syncB[gi] <= syncA[gi];
                end
            end
        end
    endgenerate
    wire extOk  = syncB[0];
    wire ethIn  = syncB[1];
    wire linked = syncB[2];

    // ==========================================================
    // millisecond and second ticks
    wire divWrap = divCnt == 17'(MS_DIV - 1);
    wire secWrap = msInSec == 10'(SEC_MS - 1);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            divCnt  <= 17'h00000;
            msTick  <= 1'b0;
            msInSec <= 10'h000;
            secTick <= 1'b0;
        end else begin
            divCnt  <= divWrap ? 17'h00000 : divCnt + 17'h00001;
            msTick  <= divWrap;
            secTick <= msTick & secWrap;
            if (msTick)
                msInSec <= secWrap ? 10'h000 : msInSec + 10'h001;
        end
    end

    nmm_press_timer u_press (
        .clk        (clk),
        .rst_n      (rst_n),
        .buttonPin  (buttonPin),
        .msTick     (msTick),
        .shortPress (shortPress),
        .longPress  (longPress)
    );

    // ==========================================================
    // source selection and charging
    wire ethUsed   = ethIn & ~extOk;
    wire extSupply = extOk | ethIn;
    wire isOff     = state == NMM_OFF;
    always_comb begin
        extPowerSelect = extOk;
        ethPowerSelect = ethUsed;
        // the node load always wins; charge only once the node is down
        chargeEnable   = extSupply & isOff;
    end

    // ==========================================================
    // mode decode
    wire isLow    = (state == NMM_SNZ_LOW) | (state == NMM_SLP_LOW);
    wire canTalk  = (state == NMM_ACTIVE) | (state == NMM_SNZ_WAKE) | (state == NMM_SLP_WAKE);
    wire snoozeGo = regWr & canTalk & (regAddr == REG_CTRL) & regWdata[CTRL_SNOOZE];
    wire sleepGo  = regWr & canTalk & (regAddr == REG_CTRL) & regWdata[CTRL_SLEEP];
    wire awakeUp  = stateSec >= awakeSec;
    wire snoozeUp = stateSec >= snoozeSec;
    wire wakeDue  = timeOfDay >= wakeTime;
    wire ledDone  = stateMs >= 16'(3 * LED_STEP_MS);
    wire onHold   = longPress & ~isOff & (state != NMM_UP) & (state != NMM_DOWN);

    // ==========================================================
    // state machine
    always_comb begin
        next_state = state;
        case (state)
            NMM_OFF: begin
                if (longPress)
                    next_state = NMM_UP;
            end
            NMM_UP: begin
                if (ledDone)
                    next_state = NMM_ACTIVE;
            end
            NMM_ACTIVE: begin
                if (sleepGo)
                    next_state = NMM_SLP_LOW;
                else if (snoozeGo)
                    next_state = NMM_SNZ_LOW;
                else if (!everLinked && !linked && awakeUp)
                    next_state = NMM_SNZ_LOW;
            end
            NMM_SNZ_LOW: begin
                if (snoozeUp)
                    next_state = NMM_SNZ_WAKE;
            end
            NMM_SNZ_WAKE: begin
                if (linked)
                    next_state = NMM_ACTIVE;
                else if (awakeUp)
                    next_state = NMM_SNZ_LOW;
            end
            NMM_SLP_LOW: begin
                if (wakeDue)
                    next_state = NMM_SLP_WAKE;
            end
            NMM_SLP_WAKE: begin
                if (linked)
                    next_state = NMM_ACTIVE;
                else if (stateSec >= DEF_AWAKE_S)
                    next_state = NMM_SNZ_LOW;
            end
            NMM_DOWN: begin
                if (ledDone)
                    next_state = NMM_OFF;
            end
            default: next_state = NMM_OFF;
        endcase
        if (onHold)
            next_state = NMM_DOWN;
    end

    wire stateChange = next_state != state;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state      <= NMM_OFF;
            stateMs    <= 16'h0000;
            stateSec   <= 16'h0000;
            everLinked <= 1'b0;
        end else begin
            state <= next_state;
            // timers restart on every transition so each phase is timed alone
            if (stateChange)
                stateMs <= 16'h0000;
            else if (msTick && stateMs != 16'hFFFF)
                stateMs <= stateMs + 16'h0001;
            if (stateChange)
                stateSec <= 16'h0000;
            else if (secTick && stateSec != 16'hFFFF)
                stateSec <= stateSec + 16'h0001;
            everLinked <= (state == NMM_ACTIVE) & ~stateChange & (everLinked | linked);
        end
    end

    // ==========================================================
    // settings and time of day
    wire wrOk = regWr & canTalk;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            standby       <= 1'b0;
            snoozeSec     <= DEF_SNOOZE_S;
            awakeSec      <= DEF_AWAKE_S;
            postSnoozeSec <= DEF_SNOOZE_S;
            wakeTime      <= 32'h00000000;
            timeOfDay     <= 32'h00000000;
        end else if (state == NMM_UP) begin
            // a power cycle forgets every user setting except wake time and time of day
            standby       <= 1'b0;
            snoozeSec     <= DEF_SNOOZE_S;
            awakeSec      <= DEF_AWAKE_S;
            postSnoozeSec <= DEF_SNOOZE_S;
        end else begin
            if (wrOk && regAddr == REG_TIME)
                timeOfDay <= regWdata;
            else if (secTick)
                timeOfDay <= timeOfDay + 32'h00000001;
            if (state == NMM_SLP_WAKE && next_state == NMM_SNZ_LOW)
                snoozeSec <= postSnoozeSec;
            else if (wrOk && regAddr == REG_SNOOZE)
                snoozeSec <= regWdata[15:0];
            if (wrOk && regAddr == REG_AWAKE)
                awakeSec <= regWdata[15:0];
            if (wrOk && regAddr == REG_POST_SNZ)
                postSnoozeSec <= regWdata[15:0];
            if (wrOk && regAddr == REG_WAKE_TIME)
                wakeTime <= regWdata;
            if (wrOk && regAddr == REG_CTRL)
                standby <= regWdata[CTRL_STANDBY];
        end
    end

    // ==========================================================
    // node outputs
    always_comb begin
        nodePowerOn        = ~isOff;
        sensorExcitationOn = (state == NMM_ACTIVE) & ~standby;
        commEnable         = canTalk;
        powerLedGreen      = 1'b0;
        powerLedRed        = 1'b0;
        if (state == NMM_UP) begin
            powerLedRed   = stateMs < 16'(2 * LED_STEP_MS);
            powerLedGreen = stateMs >= 16'(LED_STEP_MS);
        end else if (state == NMM_DOWN) begin
            powerLedGreen = stateMs < 16'(2 * LED_STEP_MS);
            powerLedRed   = (stateMs >= 16'(LED_STEP_MS)) & ~ledDone;
        end
    end

    // ==========================================================
    // charge gauge
    always_comb begin
        if (chargePct >= PCT_L5)
            gaugeLevel = 3'd5;
        else if (chargePct >= PCT_L4)
            gaugeLevel = 3'd4;
        else if (chargePct >= PCT_L3)
            gaugeLevel = 3'd3;
        else if (chargePct >= PCT_L2)
            gaugeLevel = 3'd2;
        else if (chargePct >= PCT_L1)
            gaugeLevel = 3'd1;
        else
            gaugeLevel = 3'd0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gaugeActive <= 1'b0;
            gaugeMs     <= 12'h000;
        end else if (shortPress) begin
            gaugeActive <= 1'b1;
            gaugeMs     <= 12'h000;
        end else if (msTick && gaugeActive) begin
            gaugeActive <= gaugeMs < 12'(GAUGE_HOLD_MS - 1);
            gaugeMs     <= gaugeMs + 12'h001;
        end
    end

    generate
        for (gi = 0; gi < GAUGE_LEDS; gi = gi + 1) begin : g_gauge
            // each LED waits its turn so the bar grows left to right
            always_comb begin
                gaugeGreen[gi] = gaugeActive & (gaugeLevel > 3'(gi))
                               & (gaugeMs >= 12'(gi * GAUGE_STEP_MS));
            end
        end
    endgenerate
    always_comb begin
        gaugeRed = gaugeActive & (gaugeLevel == 3'd0) & gaugeMs[FLASH_BIT];
    end

    // ==========================================================
    // register read port; reads are refused while asleep
    wire [31:0] statusWord = {25'h0000000, chargeEnable, linked, ethIn, extOk, state};
    always_comb begin
        next_rdata = 32'h00000000;
        if (!regRd || !canTalk)
            next_rdata = 32'h00000000;
        else if (regAddr == REG_CTRL)
            next_rdata = {31'h00000000, standby};
        else if (regAddr == REG_STATUS)
            next_rdata = statusWord;
        else if (regAddr == REG_SNOOZE)
            next_rdata = {16'h0000, snoozeSec};
        else if (regAddr == REG_AWAKE)
            next_rdata = {16'h0000, awakeSec};
        else if (regAddr == REG_WAKE_TIME)
            next_rdata = wakeTime;
        else if (regAddr == REG_TIME)
            next_rdata = timeOfDay;
        else if (regAddr == REG_POST_SNZ)
            next_rdata = {16'h0000, postSnoozeSec};
        else if (regAddr == REG_CHARGE)
            next_rdata = {25'h0000000, chargePct};
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            regRdata <= 32'h00000000;
        else
            regRdata <= next_rdata;
    end
endmodule : nmm_manager
`default_nettype wire

// *** hw/nmm_press_timer.sv ***
/*
 * Power button synchroniser and press timer; classifies each press on release.
 * Assumes a raw active-high button pin and a one-cycle millisecond tick.
 */
`timescale 1ns/1ns
`default_nettype none
module nmm_press_timer
    import nmm_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic buttonPin,
    input  wire logic msTick,
    output logic      shortPress,
    output logic      longPress
);
    logic        syncA;
    logic        syncB;
    logic        pressed;
    logic [11:0] pressMs;
    wire         release_ = pressed & ~syncB;
    wire         isLong   = pressMs >= 12'(LONG_PRESS_MS);

    // ==========================================================
    // sync, timing and release classification
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA      <= 1'b0;
            syncB      <= 1'b0;
            pressed    <= 1'b0;
            pressMs    <= 12'h000;
            shortPress <= 1'b0;
            longPress  <= 1'b0;
        end else begin
            syncA      <= buttonPin;
            syncB      <= syncA;
            pressed    <= syncB;
            // saturate so a very long hold stays long
            if (!syncB)
                pressMs <= 12'h000;
            else if (msTick && !isLong)
                pressMs <= pressMs + 12'h001;
            shortPress <= release_ & ~isLong;
            longPress  <= release_ & isLong;
        end
    end
endmodule : nmm_press_timer
`default_nettype wire

// *** shared/nmm_pkg.sv ***
/*
 * Constants, register map and state encoding for the node power mode manager.
 * Assumes a 125 MHz clock; every timer hangs off a millisecond tick.
 */
`default_nettype none
package nmm_pkg;
    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_NS        = 8;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned MS_CYCLES     = MS_NS / CLK_NS;
    localparam int unsigned SEC_MS        = 1000;
    localparam int unsigned LONG_PRESS_S  = 2;
    localparam int unsigned LONG_PRESS_MS = LONG_PRESS_S * SEC_MS;
    localparam int unsigned LED_STEP_MS   = 500;
    localparam int unsigned GAUGE_STEP_MS = 200;
    localparam int unsigned GAUGE_HOLD_MS = 3000;
    localparam int unsigned FLASH_BIT     = 8;
    localparam int unsigned DEF_MIN       = 2;
    localparam logic [15:0] DEF_SNOOZE_S  = 16'(DEF_MIN * 60);
    localparam logic [15:0] DEF_AWAKE_S   = 16'(DEF_MIN * 60);
    // ==========================================================
    // gauge thresholds, percent
    localparam int unsigned GAUGE_LEDS = 5;
    localparam logic [6:0]  PCT_L5     = 7'h51;
    localparam logic [6:0]  PCT_L4     = 7'h3D;
    localparam logic [6:0]  PCT_L3     = 7'h29;
    localparam logic [6:0]  PCT_L2     = 7'h15;
    localparam logic [6:0]  PCT_L1     = 7'h06;
    // ==========================================================
    // register map, word offsets
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h1;
    localparam logic [3:0]  REG_SNOOZE     = 4'h2;
    localparam logic [3:0]  REG_AWAKE      = 4'h3;
    localparam logic [3:0]  REG_WAKE_TIME  = 4'h4;
    localparam logic [3:0]  REG_TIME       = 4'h5;
    localparam logic [3:0]  REG_POST_SNZ   = 4'h6;
    localparam logic [3:0]  REG_CHARGE     = 4'h7;
    localparam int unsigned CTRL_STANDBY   = 0;
    localparam int unsigned CTRL_SNOOZE    = 1;
    localparam int unsigned CTRL_SLEEP     = 2;
    localparam int unsigned ST_EXT         = 3;
    localparam int unsigned ST_ETH         = 4;
    localparam int unsigned ST_LINK        = 5;
    localparam int unsigned ST_CHARGE      = 6;
    // ==========================================================
    // power and mode states, gray along off-up-active-snooze path
    typedef enum logic [2:0] {
        NMM_OFF      = 3'b000,
        NMM_UP       = 3'b001,
        NMM_ACTIVE   = 3'b011,
        NMM_SNZ_LOW  = 3'b010,
        NMM_SNZ_WAKE = 3'b110,
        NMM_SLP_LOW  = 3'b111,
        NMM_SLP_WAKE = 3'b101,
        NMM_DOWN     = 3'b100
    } nmm_state_t;
endpackage : nmm_pkg
`default_nettype wire

// *** testbench/nmm_checker.sv ***
/*
 * Port assertions for nmm_manager, bound into every instance.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none
module nmm_checker
    import nmm_pkg::*;
#(
    parameter int unsigned MS_DIV = MS_CYCLES
)(
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  extPresentPin,
    input wire logic                  ethPresentPin,
    input wire logic [6:0]            chargePct,
    input wire logic                  regRd,
    input wire logic [31:0]           regRdata,
    input wire logic                  nodePowerOn,
    input wire logic                  extPowerSelect,
    input wire logic                  ethPowerSelect,
    input wire logic                  chargeEnable,
    input wire logic                  sensorExcitationOn,
    input wire logic                  commEnable,
    input wire logic                  powerLedGreen,
    input wire logic                  powerLedRed,
    input wire logic                  gaugeRed,
    input wire logic [GAUGE_LEDS-1:0] gaugeGreen
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // sequences
    // level may be registered, so only judge a settled charge value
    sequence s_pct_steady;
        $stable(chargePct) [*3];
    endsequence
    sequence s_red_only;
        powerLedRed && !powerLedGreen;
    endsequence
    // ==========================================================
    // properties
    property p_ext_sel;
        extPresentPin [*5] |-> extPowerSelect;
    endproperty
    property p_eth_sel;
        (ethPresentPin && !extPresentPin) [*5] |-> ethPowerSelect;
    endproperty
    property p_eth_ignored;
        extPowerSelect |-> !ethPowerSelect;
    endproperty
    property p_charge_off;
        chargeEnable |-> !nodePowerOn;
    endproperty
    property p_charge_src;
        chargeEnable |-> extPowerSelect || ethPowerSelect;
    endproperty
    property p_sens_on;
        sensorExcitationOn |-> commEnable && nodePowerOn;
    endproperty
    property p_rd_refused;
        regRd && !commEnable |=> regRdata == 32'h0;
    endproperty
    property p_gauge_order;
        ((gaugeGreen + 5'h01) & gaugeGreen) == 5'h00;
    endproperty
    property p_gauge_top;
        s_pct_steady ##0 gaugeGreen[4] |-> chargePct >= 7'h51;
    endproperty
    property p_red_low;
        s_pct_steady ##0 gaugeRed |-> chargePct < 7'h06 && gaugeGreen == 5'h00;
    endproperty
    property p_on_led;
        $rose(nodePowerOn) |-> s_red_only;
    endproperty
    property p_off_led;
        $fell(nodePowerOn) |-> $past(powerLedRed, 2) && !$past(powerLedGreen, 2);
    endproperty
    a_ext_sel: assert property (p_ext_sel) else $error("ext select missing");
    a_eth_sel: assert property (p_eth_sel) else $error("eth select missing");
    a_eth_ignored: assert property (p_eth_ignored) else $error("eth used beside ext");
    a_charge_off: assert property (p_charge_off) else $error("charging while on");
    a_charge_src: assert property (p_charge_src) else $error("charging on battery");
    a_sens_on: assert property (p_sens_on) else $error("excitation outside active");
    a_rd_refused: assert property (p_rd_refused) else $error("read answered in low power");
    a_gauge_order: assert property (p_gauge_order) else $error("gauge not left to right");
    a_gauge_top: assert property (p_gauge_top) else $error("fifth led below band");
    a_red_low: assert property (p_red_low) else $error("red led above band");
    a_on_led: assert property (p_on_led) else $error("power up not red first");
    a_off_led: assert property (p_off_led) else $error("power down not red last");
endmodule : nmm_checker
bind nmm_manager nmm_checker #(.MS_DIV(MS_DIV)) u_nmm_checker (
    .clk(clk), .rst_n(rst_n), .extPresentPin(extPresentPin), .ethPresentPin(ethPresentPin),
    .chargePct(chargePct), .regRd(regRd), .regRdata(regRdata), .nodePowerOn(nodePowerOn),
    .extPowerSelect(extPowerSelect), .ethPowerSelect(ethPowerSelect), .chargeEnable(chargeEnable),
    .sensorExcitationOn(sensorExcitationOn), .commEnable(commEnable), .powerLedGreen(powerLedGreen),
    .powerLedRed(powerLedRed), .gaugeRed(gaugeRed), .gaugeGreen(gaugeGreen)
);
`default_nettype wire

// *** testbench/nmm_host_model.sv ***
/*
 * Host application model: connects some cycles after the node turns awake.
 * Assumes the bench says whether the host is willing to connect at all.
 */
`timescale 1ns/1ns
`default_nettype none
module nmm_host_model #(
    parameter int unsigned DELAY = 20
)(
    input  wire logic clk,
    input  wire logic commEnable,
    input  wire logic willConnect,
    output var logic  hostLinkPin
);
    int unsigned waitCnt = 0;
    initial hostLinkPin = 1'b0;
    // host cannot hold a link to a node that stopped talking
    always @(posedge clk) begin
        if (!(commEnable && willConnect)) begin
            waitCnt <= 0;
            hostLinkPin <= 1'b0;
        end else if (waitCnt < DELAY) begin
            waitCnt <= waitCnt + 1;
        end else begin
            hostLinkPin <= 1'b1;
        end
    end
endmodule : nmm_host_model
`default_nettype wire

// *** testbench/nmm_testbench.sv ***
/*
 * Self-checking bench for nmm_manager with a host model on the link pin.
 * Assumes a shortened millisecond of four cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import nmm_pkg::*;
    localparam int unsigned MSD = 4;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        buttonPin = 1'b0;
    logic        extPresentPin = 1'b0;
    logic        ethPresentPin = 1'b0;
    logic        willConnect = 1'b0;
    logic [6:0]  chargePct = 7'h32;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        hostLinkPin;
    logic [31:0] regRdata;
    logic        nodePowerOn, extPowerSelect, ethPowerSelect, chargeEnable;
    logic        sensorExcitationOn, commEnable, powerLedGreen, powerLedRed, gaugeRed;
    logic [4:0]  gaugeGreen;
    logic [6:0]  pcts [8] = '{7'h55, 7'h51, 7'h50, 7'h3D, 7'h29, 7'h15, 7'h06, 7'h05};
    int          miscompares = 0;
    int          cmpCount = 0;
    nmm_manager #(.MS_DIV(MSD)) u_nmm_manager (
        .clk(clk), .rst_n(rst_n), .buttonPin(buttonPin), .extPresentPin(extPresentPin),
        .ethPresentPin(ethPresentPin), .hostLinkPin(hostLinkPin), .chargePct(chargePct),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .nodePowerOn(nodePowerOn), .extPowerSelect(extPowerSelect), .ethPowerSelect(ethPowerSelect),
        .chargeEnable(chargeEnable), .sensorExcitationOn(sensorExcitationOn), .commEnable(commEnable),
        .powerLedGreen(powerLedGreen), .powerLedRed(powerLedRed), .gaugeRed(gaugeRed),
        .gaugeGreen(gaugeGreen));
    nmm_host_model u_nmm_host_model (
        .clk(clk), .commEnable(commEnable), .willConnect(willConnect), .hostLinkPin(hostLinkPin));
    initial begin
        forever #4 clk = ~clk;
    end
    // ==========================================================
    // tasks
    task check(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        check(regRdata, exp);
    endtask : rd
    task press(input int unsigned ms);
        @(posedge clk);
        buttonPin <= 1'b1;
        repeat (ms * MSD) @(posedge clk);
        buttonPin <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
    endtask : press
    task wait_comm(input logic lvl, input int unsigned lim);
        int unsigned n;
        n = 0;
        while (commEnable !== lvl && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({31'h0, commEnable}, {31'h0, lvl});
    endtask : wait_comm
    function automatic logic [4:0] exp_mask(input logic [6:0] p);
        return p >= 7'h51 ? 5'h1F : p >= 7'h3D ? 5'h0F : p >= 7'h29 ? 5'h07 :
               p >= 7'h15 ? 5'h03 : p >= 7'h06 ? 5'h01 : 5'h00;
    endfunction : exp_mask
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // ==========================================================
    // watchdog, run needs about 70000 cycles
    initial begin
        repeat (99000) @(posedge clk);
        miscompares++;
        end_sim;
    end
    // ==========================================================
    // tests
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_STATUS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            extPresentPin <= i[1];
            ethPresentPin <= i[0];
            repeat (6) @(posedge clk);
            #1;
            check({29'h0, extPowerSelect, ethPowerSelect, chargeEnable},
                  {29'h0, i[1], i[0] & ~i[1], i[1] | i[0]});
        end
        $display("sources done");
        press(100);
        check({27'h0, gaugeGreen}, 32'h01);
        check({31'h0, nodePowerOn}, 32'h0);
        repeat (1000 * MSD) @(posedge clk);
        foreach (pcts[k]) begin
            @(posedge clk);
            chargePct <= pcts[k];
            repeat (4) @(posedge clk);
            #1;
            check({27'h0, gaugeGreen}, {27'h0, exp_mask(pcts[k])});
        end
        repeat (300 * MSD) @(posedge clk);
        #1;
        check({26'h0, gaugeRed, gaugeGreen}, 32'h20);
        @(posedge clk);
        chargePct <= 7'h32;
        $display("gauge done");
        ethPresentPin <= 1'b0;
        press(2100);
        check({30'h0, nodePowerOn, chargeEnable}, 32'h2);
        wait_comm(1'b1, 1600 * MSD);
        rd(REG_STATUS, 32'h0B);
        rd(REG_SNOOZE, 32'h78);
        rd(REG_AWAKE, 32'h78);
        rd(4'h8, 32'h0);
        rd(REG_CHARGE, 32'h32);
        wr(REG_CTRL, 32'h1);
        rd(REG_CTRL, 32'h1);
        check({30'h0, sensorExcitationOn, commEnable}, 32'h1);
        wr(REG_CTRL, 32'h0);
        wr(REG_SNOOZE, 32'h1);
        wr(REG_AWAKE, 32'h1);
        rd(REG_SNOOZE, 32'h1);
        check({31'h0, sensorExcitationOn}, 32'h1);
        $display("power on done");
        wait_comm(1'b0, 1200 * MSD);
        rd(REG_STATUS, 32'h0);
        wait_comm(1'b1, 1200 * MSD);
        wait_comm(1'b0, 1200 * MSD);
        willConnect <= 1'b1;
        wait_comm(1'b1, 1200 * MSD);
        repeat (60) @(posedge clk);
        rd(REG_STATUS, 32'h2B);
        $display("snooze done");
        willConnect <= 1'b0;
        repeat (10) @(posedge clk);
        wr(REG_TIME, 32'h64);
        wr(REG_WAKE_TIME, 32'h65);
        wr(REG_POST_SNZ, 32'h2);
        wr(REG_CTRL, 32'h4);
        wait_comm(1'b0, 20);
        rd(REG_STATUS, 32'h0);
        wait_comm(1'b1, 1200 * MSD);
        rd(REG_TIME, 32'h65);
        rd(REG_STATUS, 32'h0D);
        willConnect <= 1'b1;
        repeat (60) @(posedge clk);
        rd(REG_STATUS, 32'h2B);
        $display("sleep done");
        press(2100);
        repeat (1600 * MSD) @(posedge clk);
        #1;
        check({30'h0, nodePowerOn, chargeEnable}, 32'h1);
        press(2100);
        wait_comm(1'b1, 1600 * MSD);
        rd(REG_SNOOZE, 32'h78);
        rd(REG_AWAKE, 32'h78);
        $display("power cycle done");
        end_sim;
    end
endmodule : testbench
`default_nettype wire
